// ==== hw/scg_top.v ====
// System clock generation unit with Wishbone register access
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "scg_map.vh"
module scg_top #(
  parameter [31:0] HARD_RCW_LOW = 32'h0204_0700,
  parameter        PCI_HALF     = `SCG_PCI_HALF_CYC
) (
  // Clock, reset, enable
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // Configuration pins
  input  wire        pci_host_select_i,
  input  wire        input_divide_strap_i,
  input  wire        hard_option_sel_i,
  input  wire [31:0] reset_config_word_low_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // PCI clock outputs
  output wire [2:0]  pci_clk_o,
  output wire        pci_sync_out_o,
  // Memory and local bus clock outputs
  output reg         memory_bus_clock_o,
  output reg         memory_bus_clock_n_o,
  output reg         local_bus_clock_output_o,
  // Unit clock enables: i2c, sd, usb, dma
  output wire [3:0]  unit_clk_en_o,
  // Derived ratios
  output reg  [3:0]  csb_to_sys_ratio_o,
  output reg  [4:0]  csb_to_sync_ratio_o,
  output reg  [6:0]  core_ratio_field_o,
  output reg  [4:0]  engine_multiplier_o,
  output reg  [1:0]  engine_divisor_o,
  output reg         lbc_double_o,
  output reg         config_error_o
);
  // Decoded multiplier; zero marks a reserved code
  function [3:0] system_multiplier_field_mult;
    input [3:0] code;
    begin
      if (code >= `SCG_SYSTEM_MULTIPLIER_FIELD_MIN && code <= `SCG_SYSTEM_MULTIPLIER_FIELD_MAX)
        system_multiplier_field_mult = code;
      else
        system_multiplier_field_mult = 4'h0;
    end
  endfunction

  function [4:0] engine_multiplier_field_mult;
    input [4:0] code;
    begin
      if (code >= `SCG_ENGINE_MULTIPLIER_FIELD_MIN && code <= `SCG_ENGINE_MULTIPLIER_FIELD_MAX)
        engine_multiplier_field_mult = code;
      else
        engine_multiplier_field_mult = 5'h00;
    end
  endfunction

  // Local bus half period in bus clock cycles, at least one
  function [3:0] lb_half;
    input [1:0] div;
    input       dbl;
    reg   [3:0] h;
    begin
      h = 4'h0;
      case (div)
        2'h0:    h = 4'h1;
        2'h1:    h = 4'h2;
        default: h = 4'h4;
      endcase
      if (dbl)
        h = {1'b0, h[3:1]};
      lb_half = (h == 4'h0) ? 4'h1 : h;
    end
  endfunction

  // Pin synchronisers
  // Straps come from pins; two flops before any logic reads them
  reg [34:0] sync1_r;
  reg [34:0] sync2_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 35'h0;
      sync2_r <= 35'h0;
    end else if (ce_i) begin
      sync1_r <= {pci_host_select_i, input_divide_strap_i,
                  hard_option_sel_i, reset_config_word_low_i};
      sync2_r <= sync1_r;
    end
  end

  // Configuration capture after reset release
  reg  [1:0]  cap_cnt_r;
  reg         host_r;
  reg         div_strap_r;
  reg  [31:0] rcw_r;
  wire [31:0] rcw_src = sync2_r[32] ? HARD_RCW_LOW : sync2_r[31:0];
  wire        cap_now = (cap_cnt_r == 2'h2);
  // Count stops at three, so the word is captured once
  reg  [1:0]  cap_cnt_nxt;
  always @* begin
    cap_cnt_nxt = cap_cnt_r;
    if (cap_cnt_r != 2'h3)
      cap_cnt_nxt = cap_cnt_r + 2'h1;
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      cap_cnt_r   <= 2'h0;
      host_r      <= 1'b0;
      div_strap_r <= 1'b0;
      rcw_r       <= 32'h0;
    end else if (ce_i) begin
      cap_cnt_r <= cap_cnt_nxt;
      if (cap_now) begin
        host_r      <= sync2_r[34];
        div_strap_r <= sync2_r[33];
        rcw_r       <= rcw_src;
      end
    end
  end
  wire cfg_ready = (cap_cnt_r == 2'h3);

  // Derived ratio fields
  wire [3:0] system_multiplier_field_code = rcw_r[`SCG_SYSTEM_MULTIPLIER_FIELD_HI:`SCG_SYSTEM_MULTIPLIER_FIELD_LO];
  wire [4:0] engine_multiplier_field_code = rcw_r[`SCG_ENGINE_MULTIPLIER_FIELD_HI:`SCG_ENGINE_MULTIPLIER_FIELD_LO];
  wire [3:0] sys_mult  = system_multiplier_field_mult(system_multiplier_field_code);
  wire [4:0] eng_mult  = engine_multiplier_field_mult(engine_multiplier_field_code);
  wire [1:0] in_factor = div_strap_r ? 2'h1 : 2'h2;
  wire       local_bus_clock_mode      = rcw_r[`SCG_LOCAL_BUS_CLOCK_MODE_BIT];
  // Reserved codes zero the ratio and raise the error flag
  reg  [3:0] sys_ratio_nxt;
  reg  [4:0] sync_ratio_nxt;
  reg  [1:0] eng_div_nxt;
  reg        cfg_err_nxt;
  always @* begin
    sys_ratio_nxt  = sys_mult;
    // Input factor two doubles the sync-to-bus ratio
    sync_ratio_nxt = {1'b0, sys_mult};
    if (in_factor == 2'h2)
      sync_ratio_nxt = {sys_mult, 1'b0};
    eng_div_nxt = 2'h1;
    if (rcw_r[`SCG_ENGINE_DIVIDER_FIELD_BIT])
      eng_div_nxt = 2'h2;
    cfg_err_nxt = (sys_mult == 4'h0) || (eng_mult == 5'h00);
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      csb_to_sys_ratio_o  <= 4'h0;
      csb_to_sync_ratio_o <= 5'h0;
      core_ratio_field_o  <= 7'h0;
      engine_multiplier_o <= 5'h0;
      engine_divisor_o    <= 2'h0;
      lbc_double_o        <= 1'b0;
      config_error_o      <= 1'b0;
    end else if (ce_i && cfg_ready) begin
      csb_to_sys_ratio_o  <= sys_ratio_nxt;
      csb_to_sync_ratio_o <= sync_ratio_nxt;
      core_ratio_field_o  <= rcw_r[`SCG_CORE_HI:`SCG_CORE_LO];
      engine_multiplier_o <= eng_mult;
      engine_divisor_o    <= eng_div_nxt;
      lbc_double_o        <= local_bus_clock_mode;
      config_error_o      <= cfg_err_nxt;
    end
  end

  // Register file
  reg [2:0] out_clk_ctrl_r;
  reg [7:0] unit_clk_ctrl_r;
  reg [1:0] lb_clk_div_r;
  // Ack high blocks a second take of the same strobe
  wire      wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes need byte lane zero
  wire      wb_wr  = wb_req && wb_we_i && wb_sel_i[0];
  reg [2:0] out_clk_ctrl_nxt;
  reg [7:0] unit_clk_ctrl_nxt;
  reg [1:0] lb_clk_div_nxt;
  always @* begin
    out_clk_ctrl_nxt  = out_clk_ctrl_r;
    unit_clk_ctrl_nxt = unit_clk_ctrl_r;
    lb_clk_div_nxt    = lb_clk_div_r;
    if (wb_wr) begin
      case (wb_adr_i)
        `SCG_ADR_OUT_CLK_CTRL:  out_clk_ctrl_nxt  = wb_dat_i[2:0];
        `SCG_ADR_UNIT_CLK_CTRL: unit_clk_ctrl_nxt = wb_dat_i[7:0];
        `SCG_ADR_LB_CLK_RATIO:  lb_clk_div_nxt    = wb_dat_i[1:0];
        default: ;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      out_clk_ctrl_r  <= `SCG_OUT_CLK_RST;
      unit_clk_ctrl_r <= `SCG_UNIT_CLK_RST;
      lb_clk_div_r    <= `SCG_LB_DIV_RST;
    end else if (ce_i) begin
      out_clk_ctrl_r  <= out_clk_ctrl_nxt;
      unit_clk_ctrl_r <= unit_clk_ctrl_nxt;
      lb_clk_div_r    <= lb_clk_div_nxt;
    end
  end

  // Read mux and acknowledge
  reg [31:0] rd_data;
  always @* begin
    rd_data = 32'h0;
    case (wb_adr_i)
      `SCG_ADR_OUT_CLK_CTRL:  rd_data = {29'h0, out_clk_ctrl_r};
      `SCG_ADR_UNIT_CLK_CTRL: rd_data = {24'h0, unit_clk_ctrl_r};
      `SCG_ADR_LB_CLK_RATIO:  rd_data = {30'h0, lb_clk_div_r};
      `SCG_ADR_STATUS:
        rd_data = {26'h0, config_error_o, cfg_ready, lbc_double_o,
                   div_strap_r, host_r, pci_sync_out_o};
      `SCG_ADR_RCW_LOW:       rd_data = rcw_r;
      `SCG_ADR_RATIOS:
        rd_data = {1'b0, engine_divisor_o, engine_multiplier_o,
                   1'b0, core_ratio_field_o, 3'h0,
                   csb_to_sync_ratio_o, 4'h0, csb_to_sys_ratio_o};
      default:                rd_data = 32'h0;
    endcase
  end

  // Read data held until the next read
  reg        ack_nxt;
  reg [31:0] dat_nxt;
  always @* begin
    ack_nxt = wb_req;
    dat_nxt = wb_dat_o;
    if (wb_req && !wb_we_i)
      dat_nxt = rd_data;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce_i) begin
      wb_ack_o <= ack_nxt;
      wb_dat_o <= dat_nxt;
    end
  end

  // PCI clock outputs
  // Agent mode or unfinished capture keeps PCI clocks low
  scg_pci_clkout #(
    .HALF (PCI_HALF)
  ) u_pci (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .host_i    (host_r && cfg_ready),
    .en_i      (out_clk_ctrl_r),
    .pci_clk_o (pci_clk_o),
    .sync_o    (pci_sync_out_o)
  );

  // Memory clock pair: controller clock halved
  // Complement taken from the old state keeps the pair exact
  reg mem_clk_nxt;
  always @* begin
    mem_clk_nxt = ~memory_bus_clock_o;
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      memory_bus_clock_o   <= 1'b0;
      memory_bus_clock_n_o <= 1'b1;
    end else if (ce_i) begin
      memory_bus_clock_o   <= mem_clk_nxt;
      memory_bus_clock_n_o <= memory_bus_clock_o;
    end
  end

  // Local bus clock divider
  reg  [3:0] lb_cnt_r;
  wire [3:0] lb_last = lb_half(lb_clk_div_r, lbc_double_o) - 4'h1;
  // Smaller ratio written mid-count wraps at once
  reg  [3:0] lb_cnt_nxt;
  reg        lb_clk_nxt;
  always @* begin
    lb_cnt_nxt = lb_cnt_r + 4'h1;
    lb_clk_nxt = local_bus_clock_output_o;
    if (lb_cnt_r >= lb_last) begin
      lb_cnt_nxt = 4'h0;
      lb_clk_nxt = ~local_bus_clock_output_o;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      lb_cnt_r                 <= 4'h0;
      local_bus_clock_output_o <= 1'b0;
    end else if (ce_i) begin
      lb_cnt_r                 <= lb_cnt_nxt;
      local_bus_clock_output_o <= lb_clk_nxt;
    end
  end

  // Unit clock enables
  // One divider per configurable unit
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_unit
      scg_ratio_div u_div (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .ratio_i (unit_clk_ctrl_r[2*g+1:2*g]),
        .en_o    (unit_clk_en_o[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ==== hw/scg_map.vh ====
// Register offsets, field positions and reset values of the clock unit
`ifndef SCG_MAP_VH
`define SCG_MAP_VH
// Register byte offsets
`define SCG_ADR_OUT_CLK_CTRL   8'h00
`define SCG_ADR_UNIT_CLK_CTRL  8'h04
`define SCG_ADR_LB_CLK_RATIO   8'h08
`define SCG_ADR_STATUS         8'h0c
`define SCG_ADR_RCW_LOW        8'h10
`define SCG_ADR_RATIOS         8'h14
// Reset configuration word low field positions
`define SCG_SYSTEM_MULTIPLIER_FIELD_HI            27
`define SCG_SYSTEM_MULTIPLIER_FIELD_LO            24
`define SCG_CORE_HI            22
`define SCG_CORE_LO            16
`define SCG_ENGINE_MULTIPLIER_FIELD_HI           12
`define SCG_ENGINE_MULTIPLIER_FIELD_LO           8
`define SCG_ENGINE_DIVIDER_FIELD_BIT          6
`define SCG_LOCAL_BUS_CLOCK_MODE_BIT           30
// Reset values
`define SCG_OUT_CLK_RST        3'h0
`define SCG_UNIT_CLK_RST       8'h55
`define SCG_LB_DIV_RST         2'h0
// Unit clock ratio codes
`define SCG_UNIT_OFF           2'h0
`define SCG_UNIT_FULL          2'h1
`define SCG_UNIT_HALF          2'h2
`define SCG_UNIT_THIRD         2'h3
// Multiplier code limits
`define SCG_SYSTEM_MULTIPLIER_FIELD_MIN           4'h2
`define SCG_SYSTEM_MULTIPLIER_FIELD_MAX           4'h6
`define SCG_ENGINE_MULTIPLIER_FIELD_MIN          5'h02
`define SCG_ENGINE_MULTIPLIER_FIELD_MAX          5'h08
// Clock rate and PCI half period
`define SCG_CLK_HZ             10000000
`define SCG_PCI_HALF_NS        100
`define SCG_PCI_HALF_CYC       ((`SCG_PCI_HALF_NS * (`SCG_CLK_HZ / 1000000)) / 1000)
`endif

// ==== hw/scg_ratio_div.v ====
// Clock-enable divider: off, full, half or one third rate
`timescale 1ns/1ns
`default_nettype none
`include "scg_map.vh"
module scg_ratio_div (
  // Clock and control
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  // Ratio select
  input  wire [1:0] ratio_i,
  // Divided enable
  output reg        en_o
);
  reg  [1:0] cnt_r;
  wire [1:0] last = (ratio_i == `SCG_UNIT_THIRD) ? 2'h2 : 2'h1;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 2'h0;
      en_o  <= 1'b0;
    end else if (ce_i) begin
      case (ratio_i)
        `SCG_UNIT_OFF: begin
          cnt_r <= 2'h0;
          en_o  <= 1'b0;
        end
        `SCG_UNIT_FULL: begin
          cnt_r <= 2'h0;
          en_o  <= 1'b1;
        end
        default: begin
          cnt_r <= (cnt_r >= last) ? 2'h0 : cnt_r + 2'h1;
          en_o  <= (cnt_r >= last);
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== hw/scg_pci_clkout.v ====
// Three phase-aligned gated PCI clock outputs and sync output
`timescale 1ns/1ns
`default_nettype none
`include "scg_map.vh"
module scg_pci_clkout #(
  parameter HALF = `SCG_PCI_HALF_CYC
) (
  // Clock and control
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  input  wire       host_i,
  input  wire [2:0] en_i,
  // Clock outputs
  output reg  [2:0] pci_clk_o,
  output reg        sync_o
);
  localparam integer HALF_I  = (HALF < 1) ? 1 : HALF;
  localparam [7:0]   HALF_M1 = HALF_I[7:0] - 8'h01;
  reg  [7:0] cnt_r;
  reg        phase_r;
  reg  [2:0] en_eff_r;
  wire       tick      = (cnt_r == HALF_M1);
  wire       phase_nxt = tick ? ~phase_r : phase_r;
  wire [2:0] en_nxt    = phase_r ? en_eff_r : en_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r     <= 8'h00;
      phase_r   <= 1'b0;
      en_eff_r  <= 3'h0;
      pci_clk_o <= 3'h0;
      sync_o    <= 1'b0;
    end else if (ce_i) begin
      if (!host_i) begin
        cnt_r     <= 8'h00;
        phase_r   <= 1'b0;
        en_eff_r  <= 3'h0;
        pci_clk_o <= 3'h0;
        sync_o    <= 1'b0;
      end else begin
        cnt_r    <= tick ? 8'h00 : cnt_r + 8'h01;
        phase_r  <= phase_nxt;
        en_eff_r <= en_nxt;
        pci_clk_o <= {3{phase_nxt}} & en_nxt;
        sync_o   <= phase_nxt;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/scg_pci_agent.sv ====
// Behavioural PCI agent that counts clock rises
`timescale 1ns/1ns
`default_nettype none
module scg_pci_agent (
  // Clear and agent clock
  input  wire logic       clr_i,
  input  wire logic       pci_clk_i,
  // Rise count
  output var  logic [7:0] rise_n_o
);
  // One agent per output
  always @(posedge pci_clk_i or posedge clr_i) begin
    if (clr_i) begin
      rise_n_o <= 8'h00;
    end else begin
      rise_n_o <= rise_n_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== tb/scg_top_sva.sv ====
// Port checker for the clock unit
`timescale 1ns/1ns
`default_nettype none
module scg_top_chk (
  // Clock, reset, bus
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       pci_host_select_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // Clock outputs
  input wire logic [2:0] pci_clk_o,
  input wire logic       pci_sync_out_o,
  input wire logic       memory_bus_clock_o,
  input wire logic       memory_bus_clock_n_o,
  // Ratio
  input wire logic [3:0] csb_to_sys_ratio_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_pci_reset_low: assert property (
    disable iff (1'b0) rst_i |=> pci_clk_o == 3'h0)
    else $error("pci clock high after reset");
  a_pci_phase: assert property (
    (pci_clk_o & ~{3{pci_sync_out_o}}) == 3'h0)
    else $error("pci clock out of phase");
  a_pci_start: assert property (
    $rose(pci_clk_o[1]) |-> $rose(pci_sync_out_o))
    else $error("pci clock started mid phase");
  a_pci_no_runt: assert property (
    $fell(pci_clk_o[0]) |-> $fell(pci_sync_out_o))
    else $error("pci clock short pulse");
  a_agent_quiet: assert property (
    !pci_host_select_i && $past(!pci_host_select_i, 4)
    |-> pci_clk_o == 3'h0 && !pci_sync_out_o)
    else $error("clock outputs active in agent mode");
  a_mem_pair: assert property (
    memory_bus_clock_o != memory_bus_clock_n_o)
    else $error("memory clock pair not complementary");
  a_mem_toggle: assert property (
    $past(!rst_i, 2) |-> memory_bus_clock_o != $past(memory_bus_clock_o))
    else $error("memory clock not halved");
  a_sys_legal: assert property (
    csb_to_sys_ratio_o != 4'h0 |-> csb_to_sys_ratio_o inside {[4'h2:4'h6]})
    else $error("reserved system multiplier used");
  a_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not acknowledged");
endmodule
bind scg_top scg_top_chk u_chk (.*);
`default_nettype wire

// ==== tb/system_clock_generation_bench.sv ====
// Self-checking bench for the clock unit
`timescale 1ns/1ns
`default_nettype none
module system_clock_generation_bench;
  localparam [31:0] HARD = 32'h0305_0440;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        pci_host_select_i = 1'b1;
  logic        input_divide_strap_i = 1'b0;
  logic        hard_option_sel_i = 1'b0;
  logic [31:0] reset_config_word_low_i = 32'h0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, pci_sync_out_o, local_bus_clock_output_o;
  wire         memory_bus_clock_o, memory_bus_clock_n_o;
  wire         lbc_double_o, config_error_o;
  wire  [2:0]  pci_clk_o;
  wire  [3:0]  unit_clk_en_o, csb_to_sys_ratio_o;
  wire  [4:0]  csb_to_sync_ratio_o, engine_multiplier_o;
  wire  [6:0]  core_ratio_field_o;
  wire  [1:0]  engine_divisor_o;
  wire  [7:0]  rn [3];
  logic [31:0] exq [$];
  logic        clr = 1'b1;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc_n = 0;
  int          uc [4];
  int          lt;
  scg_top #(.HARD_RCW_LOW(HARD), .PCI_HALF(1)) uut (.*);
  for (genvar k = 0; k < 3; k++) begin : g_ag
    scg_pci_agent ag (.clr_i(clr), .pci_clk_i(pci_clk_o[k]),
                      .rise_n_o(rn[k]));
  end
  always #50 clk_i = ~clk_i;
  task automatic wrap_up();
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    n_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  // Reads queue their expected data
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    if (!w)
      exq.push_back(d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
    if (n >= 20)
      fail_count++;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      chk(wb_dat_o, exq.pop_front());
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic boot(input logic h, input logic hs, input logic [31:0] w);
    @(posedge clk_i);
    rst_i <= 1'b1;
    pci_host_select_i <= h;
    hard_option_sel_i <= hs;
    reset_config_word_low_i <= w;
    input_divide_strap_i <= 1'($urandom);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask
  // Clears agents, then counts unit pulses and bus clock edges
  task automatic run(input int n);
    logic p;
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    p = local_bus_clock_output_o;
    lt = 0;
    uc = '{4{0}};
    repeat (n) begin
      @(posedge clk_i);
      for (int k = 0; k < 4; k++)
        uc[k] += unit_clk_en_o[k];
      lt += int'(local_bus_clock_output_o !== p);
      p = local_bus_clock_output_o;
    end
  endtask
  initial begin
    logic [3:0]  s;
    logic [4:0]  m;
    logic [31:0] w, e;
    int          h;
    int          ue [4] = '{0, 12, 6, 4};
    void'($urandom(23));
    s = 4'(2 + $urandom % 5);
    m = 5'(2 + $urandom % 7);
    w = $urandom;
    w[27:24] = s;
    w[12:8] = m;
    boot(1'b1, 1'b0, w);
    wb(0, 8'h10, w);
    e = {1'b0, 2'(1 + w[6]), m, 1'b0, w[22:16], 3'h0,
         5'(s * (input_divide_strap_i ? 1 : 2)), 4'h0, s};
    wb(0, 8'h14, e);
    chk({31'h0, config_error_o}, 32'h0);
    wb(0, 8'h00, 32'h0);
    wb(0, 8'h04, 32'h55);
    wb(0, 8'h08, 32'h0);
    wb(0, 8'h3c, 32'h0);
    run(20);
    chk({24'h0, rn[0] | rn[1] | rn[2]}, 32'h0);
    e = $urandom % 7 + 1;
    wb(1, 8'h00, e);
    run(20);
    for (int k = 0; k < 3; k++)
      chk(32'(rn[k] != 8'h0), 32'(e[k]));
    wb(1, 8'h00, 32'h0);
    run(2);
    run(10);
    chk({24'h0, rn[0] | rn[1] | rn[2]}, 32'h0);
    wb(1, 8'h04, 32'he4);
    run(4);
    run(12);
    for (int k = 0; k < 4; k++)
      chk(32'(uc[k]), 32'(ue[k]));
    for (int c = 0; c < 4; c++) begin
      wb(1, 8'h08, 32'(c));
      run(8);
      run(32);
      h = (c == 0) ? 1 : (c == 1) ? 2 : 4;
      if (w[30] && h > 1)
        h = h / 2;
      chk(32'(lt), 32'(32 / h));
    end
    w[27:24] = 4'h7 + 4'($urandom % 9);
    w[12:8] = 5'h09;
    boot(1'b1, 1'b0, w);
    chk({31'h0, config_error_o}, 32'h1);
    wb(0, 8'h14, {1'b0, 2'(1 + w[6]), 6'h0, w[22:16], 16'h0});
    boot(1'b1, 1'b1, w);
    wb(0, 8'h10, HARD);
    boot(1'b0, 1'b0, HARD);
    wb(1, 8'h00, 32'h7);
    run(20);
    chk({24'h0, rn[0] | rn[1] | rn[2]}, 32'h0);
    wb(0, 8'h0c, 32'h10 | (32'(input_divide_strap_i) << 2));
    wrap_up();
  end
endmodule
`default_nettype wire
